// File: design/hsfs_pkg.sv
// Shared constants and types of the high side fault supervisor
package hsfs_pkg;

	// ========================================
	// Clock and timing
	localparam int CLK_PERIOD_NS = 50;
	localparam int CL_DGL_NS = 2500;
	localparam int REL_DGL_NS = 2500;
	localparam int ABS_DGL_NS = 20000;
	localparam int OL_DGL_NS = 500000;
	// Least times, so round up to whole cycles
	localparam int CL_DGL_CYC = (CL_DGL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REL_DGL_CYC = (REL_DGL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ABS_DGL_CYC = (ABS_DGL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OL_DGL_CYC = (OL_DGL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Retry and standby deglitch durations are free choices
	localparam int RETRY_NS = 1000000;
	localparam int STBY_NS = 2000000;
	localparam int RETRY_CYC = (RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STBY_CYC = (STBY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DGL_CNT_W = 16;
	localparam int LONG_CNT_W = 24;

	// ========================================
	// Qualified fault indices
	localparam int Q_CL = 0;
	localparam int Q_REL = 1;
	localparam int Q_ABS = 2;
	localparam int Q_OL = 3;
	localparam int NUM_Q = 4;

	// ========================================
	// Register map
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_EVENT = 8'h08;
	localparam logic CTRL_RST = 1'b0;
	localparam int CTRL_FORCE_OFF = 0;
	localparam int EV_CL = 0;
	localparam int EV_TSD = 1;
	localparam int EV_OL = 2;
	localparam int EV_UV = 3;
	localparam int EV_LOSS = 4;
	localparam int NUM_EV = 5;
	localparam logic [NUM_EV-1:0] EVENT_RST = 5'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ========================================
	// Types
	typedef enum logic [1:0] {MODE_NORMAL, MODE_STANDBY, MODE_STANDBY_DIAG} hsfs_mode_t;
	typedef enum logic [1:0] {CH_OFF, CH_ON, CH_RETRY, CH_LATCHED} hsfs_chan_t;
	typedef enum logic [1:0] {SEL_CTRL, SEL_STATUS, SEL_EVENT, SEL_NONE} hsfs_sel_t;

endpackage

// File: design/hsfs_dgl_if.sv
// Raw and qualified fault conditions between supervisor and deglitch filter
`timescale 1ns/1ps
`default_nettype none
interface hsfs_dgl_if;
	logic [3:0] raw;
	logic [3:0] qual;
	modport filt (input raw, output qual);
	modport sup (output raw, input qual);
endinterface
`default_nettype wire

// File: design/hsfs_deglitch.sv
// Per-condition deglitch filter: sets after a steady run, clears at once
`timescale 1ns/1ps
`default_nettype none
module hsfs_deglitch import hsfs_pkg::*; #(
	parameter int unsigned CL_CYC = CL_DGL_CYC,
	parameter int unsigned REL_CYC = REL_DGL_CYC,
	parameter int unsigned ABS_CYC = ABS_DGL_CYC,
	parameter int unsigned OL_CYC = OL_DGL_CYC
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// Conditions
	hsfs_dgl_if.filt dg
);

	logic [DGL_CNT_W-1:0] cnt_r [NUM_Q];
	logic [3:0] qual_r;

	function automatic logic [DGL_CNT_W-1:0] lim_of(input int idx);
		unique case (idx)
			Q_CL: lim_of = DGL_CNT_W'(CL_CYC - 1);
			Q_REL: lim_of = DGL_CNT_W'(REL_CYC - 1);
			Q_ABS: lim_of = DGL_CNT_W'(ABS_CYC - 1);
			default: lim_of = DGL_CNT_W'(OL_CYC - 1);
		endcase
	endfunction

	// ========================================
	// Filters
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NUM_Q; i++) begin
				cnt_r[i] <= '0;
			end
			qual_r <= '0;
		end else if (clk_en) begin
			for (int i = 0; i < NUM_Q; i++) begin
				if (!dg.raw[i]) begin
					cnt_r[i] <= '0;
					qual_r[i] <= 1'b0;
				end else if (cnt_r[i] == lim_of(i)) begin
					qual_r[i] <= 1'b1;
				end else begin
					cnt_r[i] <= cnt_r[i] + 1'b1;
				end
			end
		end
	end

	assign dg.qual = qual_r;

endmodule
`default_nettype wire

// File: design/hsfs_supervisor.sv
// Fault supervisor of a single-channel high side switch with AXI4-Lite status
//
// Overview of operation
// - Off-state open load: fault line low, sense full-scale
// - Open-load pull-up connected only while diagnostics enabled
// - Short to battery reported exactly like open load
// - Latch-select picks latch-off or automatic retry
// - After retry wait, latch low restarts channel
// - Latch high after wait keeps channel off
// - Release with latch low resumes auto-retry
// - Release with latch high resumes latch mode
// - Current limit drives fault line and full-scale sense
// - Relative thermal trip shuts channel down
// - Fault stays shown during shutdown and retry wait
// - Absolute trip waits for hysteresis and retry time
// - Latch mode holds off until latch/enable toggle
// - Protection works regardless of diagnostic enable
// - Undervoltage lockout with fall and rise thresholds
// - Ground or supply loss forces output off
// - Diagnostic enable multiplexes sense/status reporting
// - Three working modes: normal, standby, standby diagnostic
// - Standby only after enable low past deglitch
// - Deglitch: 2.5 us, 2.5 us, 20 us, 500 us
// - Off-state open-load indication clears by itself
//
// The implementer's own choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module hsfs_supervisor import hsfs_pkg::*; #(
	parameter int unsigned ADDR_W = 8,
	parameter int unsigned RETRY_CNT = RETRY_CYC,
	parameter int unsigned STBY_CNT = STBY_CYC,
	parameter int unsigned OL_CNT = OL_DGL_CYC
) (
	// Clock, reset, clock enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// AXI4-Lite write
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Host control pins
	input wire logic enable_in,
	input wire logic latch_select,
	input wire logic sense_report_enable,
	// Analog comparator events
	input wire logic current_limit_trip,
	input wire logic relative_temp_trip,
	input wire logic absolute_temp_trip,
	input wire logic abs_temp_recovered,
	input wire logic offstate_openload_margin,
	input wire logic supply_low_fall_trip,
	input wire logic supply_low_rise_trip,
	input wire logic ground_lost,
	input wire logic supply_lost,
	// Power stage and diagnostic outputs
	output logic channel_drive,
	output logic fault_status_n_o,
	output logic fault_status_n_oe,
	output logic sense_fault_level,
	output logic sense_current_en,
	output logic openload_pullup_en,
	output var hsfs_mode_t work_mode
);

	hsfs_dgl_if dg ();

	hsfs_chan_t chan_r;
	logic abs_hit_r;
	logic [LONG_CNT_W-1:0] retry_cnt_r;
	logic [LONG_CNT_W-1:0] stby_cnt_r;
	logic uv_lock_r;
	logic force_off_r;
	logic [NUM_EV-1:0] event_r;
	logic [NUM_EV-1:0] ev_set;
	logic [NUM_EV-1:0] ev_clr;
	logic kill;
	logic fault_active;
	logic fault_report;
	logic drive_nxt;
	logic aw_got_r;
	logic w_got_r;
	logic [ADDR_W-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_fire;
	hsfs_sel_t wr_sel;
	logic [31:0] rd_word;

	function automatic hsfs_sel_t decode(input logic [ADDR_W-1:0] addr);
		if (addr == ADDR_W'(REG_CTRL)) begin
			decode = SEL_CTRL;
		end else if (addr == ADDR_W'(REG_STATUS)) begin
			decode = SEL_STATUS;
		end else if (addr == ADDR_W'(REG_EVENT)) begin
			decode = SEL_EVENT;
		end else begin
			decode = SEL_NONE;
		end
	endfunction

	// ========================================
	// Fault qualification
	// Current limit only counts while the stage is driven; open load is
	// only seen with the pull-up in place, i.e. with diagnostics enabled
	assign dg.raw[Q_CL] = current_limit_trip & channel_drive;
	assign dg.raw[Q_REL] = relative_temp_trip;
	assign dg.raw[Q_ABS] = absolute_temp_trip;
	assign dg.raw[Q_OL] = offstate_openload_margin & ~channel_drive & sense_report_enable;

	hsfs_deglitch #(
		.CL_CYC(CL_DGL_CYC),
		.REL_CYC(REL_DGL_CYC),
		.ABS_CYC(ABS_DGL_CYC),
		.OL_CYC(OL_CNT)
	) u_dgl (
		.aclk(aclk),
		.aresetn(aresetn),
		.clk_en(clk_en),
		.dg(dg.filt)
	);

	// ========================================
	// Undervoltage lockout with hysteresis
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			uv_lock_r <= 1'b1;
		end else if (clk_en) begin
			if (supply_low_fall_trip) begin
				uv_lock_r <= 1'b1;
			end else if (supply_low_rise_trip) begin
				uv_lock_r <= 1'b0;
			end
		end
	end

	assign kill = uv_lock_r | ground_lost | supply_lost | force_off_r;

	// ========================================
	// Channel recovery state machine
	// Thermal trips act whatever the diagnostic enable says
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chan_r <= CH_OFF;
			abs_hit_r <= 1'b0;
			retry_cnt_r <= '0;
		end else if (clk_en) begin
			unique case (chan_r)
				CH_OFF: begin
					if (enable_in) begin
						chan_r <= CH_ON;
					end
				end
				CH_ON: begin
					if (!enable_in) begin
						chan_r <= CH_OFF;
					end else if (dg.qual[Q_REL] || dg.qual[Q_ABS]) begin
						chan_r <= CH_RETRY;
						abs_hit_r <= dg.qual[Q_ABS];
						retry_cnt_r <= '0;
					end
				end
				CH_RETRY: begin
					if (retry_cnt_r != LONG_CNT_W'(RETRY_CNT - 1)) begin
						retry_cnt_r <= retry_cnt_r + 1'b1;
					end else if (!abs_hit_r || abs_temp_recovered) begin
						if (latch_select) begin
							chan_r <= CH_LATCHED;
						end else if (enable_in) begin
							chan_r <= CH_ON;
						end else begin
							chan_r <= CH_OFF;
						end
					end
				end
				CH_LATCHED: begin
					// Latch is read live, so a later fault follows its level
					if (!enable_in) begin
						chan_r <= CH_OFF;
					end else if (!latch_select) begin
						chan_r <= CH_ON;
					end
				end
			endcase
		end
	end

	assign drive_nxt = (chan_r == CH_ON) & enable_in & ~kill;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			channel_drive <= 1'b0;
		end else if (clk_en) begin
			channel_drive <= drive_nxt;
		end
	end

	// ========================================
	// Diagnostic reporting
	assign fault_active = (dg.qual[Q_CL] & channel_drive)
		| (chan_r == CH_RETRY) | (chan_r == CH_LATCHED)
		| dg.qual[Q_OL];
	assign fault_report = fault_active & sense_report_enable;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_status_n_o <= 1'b0;
			fault_status_n_oe <= 1'b0;
			sense_fault_level <= 1'b0;
			sense_current_en <= 1'b0;
			openload_pullup_en <= 1'b0;
		end else if (clk_en) begin
			// Open drain: only ever pulls low, released otherwise
			fault_status_n_o <= 1'b0;
			fault_status_n_oe <= fault_report;
			sense_fault_level <= fault_report;
			sense_current_en <= sense_report_enable & drive_nxt & ~fault_active;
			openload_pullup_en <= sense_report_enable;
		end
	end

	// ========================================
	// Working mode with standby deglitch
	// A PWM low phase shorter than the deglitch never reaches standby
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			stby_cnt_r <= '0;
			work_mode <= MODE_NORMAL;
		end else if (clk_en) begin
			if (enable_in) begin
				stby_cnt_r <= '0;
				work_mode <= MODE_NORMAL;
			end else if (stby_cnt_r != LONG_CNT_W'(STBY_CNT - 1)) begin
				stby_cnt_r <= stby_cnt_r + 1'b1;
			end else begin
				work_mode <= sense_report_enable ? MODE_STANDBY_DIAG : MODE_STANDBY;
			end
		end
	end

	// ========================================
	// Event flags, write one to clear, a new event beats the clear
	assign ev_set[EV_CL] = dg.qual[Q_CL] & channel_drive;
	assign ev_set[EV_TSD] = chan_r == CH_ON && enable_in && (dg.qual[Q_REL] || dg.qual[Q_ABS]);
	assign ev_set[EV_OL] = dg.qual[Q_OL];
	assign ev_set[EV_UV] = uv_lock_r;
	assign ev_set[EV_LOSS] = ground_lost | supply_lost;
	assign ev_clr = (wr_fire && wr_sel == SEL_EVENT && wstrb_r[0]) ? wdata_r[NUM_EV-1:0] : '0;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			event_r <= EVENT_RST;
		end else if (clk_en) begin
			event_r <= (event_r & ~ev_clr) | ev_set;
		end
	end

	// ========================================
	// AXI4-Lite write channel
	assign wr_fire = aw_got_r & w_got_r & ~s_axi_bvalid;
	assign wr_sel = decode(awaddr_r);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= '0;
			wstrb_r <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (clk_en) begin
			s_axi_awready <= ~aw_got_r & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready <= ~w_got_r & ~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			force_off_r <= CTRL_RST;
		end else if (clk_en) begin
			if (wr_fire && wr_sel == SEL_CTRL && wstrb_r[0]) begin
				force_off_r <= wdata_r[CTRL_FORCE_OFF];
			end
		end
	end

	// ========================================
	// AXI4-Lite read channel
	always_comb begin
		rd_word = '0;
		unique case (decode(s_axi_araddr))
			SEL_CTRL: rd_word[CTRL_FORCE_OFF] = force_off_r;
			SEL_STATUS: rd_word = {21'h000000, uv_lock_r, dg.qual, work_mode,
				chan_r == CH_RETRY, chan_r == CH_LATCHED, fault_active, channel_drive};
			SEL_EVENT: rd_word[NUM_EV-1:0] = event_r;
			SEL_NONE: rd_word = '0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (clk_en) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= (decode(s_axi_araddr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end else if (!s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

endmodule
`default_nettype wire

// File: test/hsfs_props.sv
// Port-level assertions of the fault supervisor
`timescale 1ns/1ps
`default_nettype none
module hsfs_props import hsfs_pkg::*; #(
	parameter int unsigned STBY_CNT = STBY_CYC
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	// Pins and comparators
	input wire logic enable_in,
	input wire logic sense_report_enable,
	input wire logic current_limit_trip,
	input wire logic supply_low_fall_trip,
	input wire logic ground_lost,
	input wire logic supply_lost,
	// Outputs
	input wire logic channel_drive,
	input wire logic fault_status_n_o,
	input wire logic fault_status_n_oe,
	input wire logic sense_fault_level,
	input wire logic openload_pullup_en,
	input wire hsfs_mode_t work_mode
);
	// ========================================
	// Run counters, too long for a repetition
	logic [5:0] cl_cnt_r;
	logic [31:0] lo_cnt_r;
	always_ff @(posedge aclk) begin
		if (!aresetn)
			cl_cnt_r <= 6'h00;
		else if (clk_en)
			cl_cnt_r <= (current_limit_trip && channel_drive && sense_report_enable) ?
				cl_cnt_r + {5'h00, cl_cnt_r != 6'h3F} : 6'h00;
	end
	always_ff @(posedge aclk) begin
		if (!aresetn)
			lo_cnt_r <= 32'h0;
		else if (clk_en)
			lo_cnt_r <= enable_in ? 32'h0 : lo_cnt_r + 32'h1;
	end
	// ========================================
	// Properties
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Deglitch of 50 edges plus one output edge, with margin
	sequence cl_held;
		cl_cnt_r >= 52;
	endsequence
	sequence low_long;
		lo_cnt_r >= STBY_CNT;
	endsequence
	loss_off_a: assert property (clk_en && (ground_lost || supply_lost) |=> !channel_drive)
		else $error("channel driven after supply or ground loss");
	// Lockout flop first, then the drive flop: two edges to the cut-off
	uv_off_a: assert property (clk_en && supply_low_fall_trip ##1 clk_en |=> !channel_drive)
		else $error("channel driven in undervoltage");
	pullup_follow_a: assert property (clk_en |=> openload_pullup_en == $past(sense_report_enable))
		else $error("pull-up not following diagnostic enable");
	report_gate_a: assert property (clk_en && !sense_report_enable |=> !fault_status_n_oe && !sense_fault_level)
		else $error("fault reported with diagnostics disabled");
	od_low_a: assert property (fault_status_n_oe |-> !fault_status_n_o)
		else $error("fault line driven high");
	fault_pair_a: assert property (fault_status_n_oe == sense_fault_level)
		else $error("fault line and sense level disagree");
	cl_report_a: assert property (cl_held |-> fault_status_n_oe && sense_fault_level)
		else $error("current limit not reported");
	stby_entry_a: assert property ($rose(work_mode != MODE_NORMAL) |-> low_long)
		else $error("standby entered too early");
endmodule
bind hsfs_supervisor hsfs_props #(.STBY_CNT(STBY_CNT)) hsfs_props_i (.aclk, .aresetn, .clk_en, .enable_in,
	.sense_report_enable, .current_limit_trip, .supply_low_fall_trip, .ground_lost, .supply_lost,
	.channel_drive, .fault_status_n_o, .fault_status_n_oe, .sense_fault_level, .openload_pullup_en, .work_mode);
`default_nettype wire

// File: test/hsfs_host.sv
// Host controller model: control pins and fault line read-back
`timescale 1ns/1ps
`default_nettype none
module hsfs_host (
	// Clock
	input wire logic aclk,
	// Requests from the sequence
	input wire logic want_en,
	input wire logic want_latch,
	input wire logic want_diag,
	// Control pins
	output logic enable_in,
	output logic latch_select,
	output logic sense_report_enable,
	// Diagnostic pins
	input wire logic fault_status_n_o,
	input wire logic fault_status_n_oe,
	input wire logic sense_fault_level,
	input wire logic sense_current_en,
	output logic fault_line,
	output logic load_judge_on
);
	// GPIO changes only just after an edge
	always @(posedge aclk) begin
		enable_in <= want_en;
		latch_select <= want_latch;
		sense_report_enable <= want_diag;
	end
	// Released line rests at the board pull-up
	assign fault_line = fault_status_n_oe ? fault_status_n_o : 1'b1;
	// On-state open load is judged here from the sense reading
	assign load_judge_on = sense_current_en && !sense_fault_level;
endmodule
`default_nettype wire

// File: test/high_side_fault_supervisor_test.sv
// Self-checking testbench of the fault supervisor
`timescale 1ns/1ps
`default_nettype none
module high_side_fault_supervisor_test import hsfs_pkg::*;;
	// ========================================
	// Signals
	logic aclk = 1'b0, aresetn = 1'b0, clk_en = 1'b1;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic [3:0] wstrb = 4'hF;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic cl = 1'b0, rel = 1'b0, ab = 1'b0, abr = 1'b0, olm = 1'b0, uvf = 1'b0, uvr = 1'b0, gl = 1'b0, sl = 1'b0;
	logic w_en = 1'b0, w_lat = 1'b0, w_diag = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, en, lat, sre, cd, fo, foe, sfl, sce, pue, fline, lj;
	logic [1:0] bresp, rresp;
	hsfs_mode_t wm;
	int mismatches = 0, n_tests = 0;
	always #25 aclk = ~aclk;
	hsfs_supervisor #(.RETRY_CNT(20), .STBY_CNT(10), .OL_CNT(20)) hsfs_supervisor_i (
		.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .enable_in(en), .latch_select(lat),
		.sense_report_enable(sre), .current_limit_trip(cl), .relative_temp_trip(rel), .absolute_temp_trip(ab),
		.abs_temp_recovered(abr), .offstate_openload_margin(olm), .supply_low_fall_trip(uvf),
		.supply_low_rise_trip(uvr), .ground_lost(gl), .supply_lost(sl), .channel_drive(cd),
		.fault_status_n_o(fo), .fault_status_n_oe(foe), .sense_fault_level(sfl), .sense_current_en(sce),
		.openload_pullup_en(pue), .work_mode(wm));
	hsfs_host hsfs_host_i (.aclk(aclk), .want_en(w_en), .want_latch(w_lat), .want_diag(w_diag), .enable_in(en),
		.latch_select(lat), .sense_report_enable(sre), .fault_status_n_o(fo), .fault_status_n_oe(foe),
		.sense_fault_level(sfl), .sense_current_en(sce), .fault_line(fline), .load_judge_on(lj));
	// ========================================
	// Tasks
	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wait_cd(input logic v);
		int n;
		n = 0;
		while (cd !== v && n < 100) begin
			@(posedge aclk);
			n++;
		end
		chk(cd, v);
		if (n == 100)
			end_sim();
	endtask
	// One write or read; each channel held until its ready is sampled
	task automatic axi(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er,
		output logic [31:0] r);
		int n;
		logic ta, tw;
		n = 0;
		ta = !wr;
		tw = 1'b0;
		@(posedge aclk);
		if (wr) begin
			awaddr <= a;
			wdata <= d;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
		end else begin
			araddr <= a;
			arvalid <= 1'b1;
			rready <= 1'b1;
		end
		while (!(ta && tw) && n < 100) begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) begin
				ta = 1'b1;
				awvalid <= 1'b0;
			end
			if ((wvalid && wready) || (arvalid && arready)) begin
				tw = 1'b1;
				wvalid <= 1'b0;
				arvalid <= 1'b0;
			end
		end
		do begin
			@(posedge aclk);
			n++;
		end while (!(wr ? bvalid === 1'b1 : rvalid === 1'b1) && n < 100);
		bready <= 1'b0;
		rready <= 1'b0;
		r = rdata;
		chk(wr ? bresp : rresp, er);
		if (n >= 100) begin
			mismatches++;
			end_sim();
		end
	endtask
	task automatic heat;
		w_lat <= 1'b1;
		rel <= 1'b1;
		cyc(55);
		rel <= 1'b0;
		cyc(40);
	endtask
	// ========================================
	// Sequence
	initial begin
		cyc(100000);
		mismatches++;
		end_sim();
	end
	initial begin
		cyc(16);
		aresetn <= 1'b1;
		w_en <= 1'b1;
		w_diag <= 1'b1;
		axi(1'b0, REG_CTRL, 32'h0, RESP_OKAY, q);
		chk(q, 32'h0);
		uvr <= 1'b1;
		cyc(2);
		uvr <= 1'b0;
		wait_cd(1'b1);
		cl <= 1'b1;
		cyc(60);
		chk({foe, sfl, cd, fline, sce}, 5'h1C);
		rel <= 1'b1;
		cyc(60);
		chk({foe, sfl, cd, fline}, 4'hC);
		cl <= 1'b0;
		rel <= 1'b0;
		wait_cd(1'b1);
		heat();
		chk({cd, foe}, 2'h1);
		w_lat <= 1'b0;
		wait_cd(1'b1);
		heat();
		w_en <= 1'b0;
		cyc(3);
		chk(wm, MODE_NORMAL);
		w_en <= 1'b1;
		wait_cd(1'b1);
		heat();
		chk(cd, 1'b0);
		w_lat <= 1'b0;
		wait_cd(1'b1);
		ab <= 1'b1;
		cyc(410);
		ab <= 1'b0;
		cyc(40);
		chk({cd, foe}, 2'h1);
		abr <= 1'b1;
		wait_cd(1'b1);
		axi(1'b0, REG_EVENT, 32'h0, RESP_OKAY, q);
		chk(q & 32'h3, 32'h3);
		axi(1'b1, REG_EVENT, 32'h3, RESP_OKAY, q);
		axi(1'b0, REG_EVENT, 32'h0, RESP_OKAY, q);
		chk(q & 32'h3, 32'h0);
		axi(1'b1, REG_STATUS, 32'hFFFF, RESP_OKAY, q);
		axi(1'b1, REG_CTRL, 32'h1, RESP_OKAY, q);
		wait_cd(1'b0);
		axi(1'b0, REG_CTRL, 32'h0, RESP_OKAY, q);
		chk(q, 32'h1);
		axi(1'b1, REG_CTRL, 32'h0, RESP_OKAY, q);
		wait_cd(1'b1);
		// Channel on, no fault: only the drive bit of the status word
		axi(1'b0, REG_STATUS, 32'h0, RESP_OKAY, q);
		chk(q, 32'h1);
		// Low byte strobe off: the control write must be dropped
		wstrb <= 4'hE;
		axi(1'b1, REG_CTRL, 32'h1, RESP_OKAY, q);
		wstrb <= 4'hF;
		axi(1'b0, REG_CTRL, 32'h0, RESP_OKAY, q);
		chk(q, 32'h0);
		axi(1'b1, 8'h0C, 32'h5, RESP_SLVERR, q);
		axi(1'b0, 8'h0C, 32'h0, RESP_SLVERR, q);
		chk({sce, lj}, 2'h3);
		// Frozen clock enable: a long current limit must not qualify
		clk_en <= 1'b0;
		cl <= 1'b1;
		cyc(60);
		chk({foe, cd, sce}, 3'h3);
		cl <= 1'b0;
		clk_en <= 1'b1;
		// Cut-offs with reporting disabled: protection must still act
		w_diag <= 1'b0;
		cyc(3);
		for (int i = 0; i < 3; i++) begin
			{uvf, gl, sl} <= 3'h4 >> i;
			cyc(3);
			chk({cd, foe, sfl}, 3'h0);
			{uvf, gl, sl} <= 3'h0;
			uvr <= 1'b1;
			cyc(2);
			uvr <= 1'b0;
			wait_cd(1'b1);
		end
		w_diag <= 1'b1;
		w_en <= 1'b0;
		olm <= 1'b1;
		cyc(40);
		chk({foe, sfl, cd, pue}, 4'hD);
		chk(wm, MODE_STANDBY_DIAG);
		olm <= 1'b0;
		cyc(3);
		chk({foe, sfl}, 2'h0);
		w_diag <= 1'b0;
		cyc(3);
		chk({pue, wm}, {1'b0, MODE_STANDBY});
		w_en <= 1'b1;
		cyc(3);
		chk(wm, MODE_NORMAL);
		end_sim();
	end
endmodule
`default_nettype wire
